// >>> rtl/pvr_seq.sv
/*
 * Source-side sequencer for a contract change raising voltage and current.
 * It sends Accept, waits the transition interval after the GoodCRC, orders
 * the supply up, awaits readiness, sends PS_RDY and ends on its GoodCRC.
 * Assumes the protocol layer takes a one-cycle send pulse and reports each
 * GoodCRC with a one-cycle pulse; the supply reports ready as a level.
 */
`timescale 1ns/1ps
`include "pvr_params.svh"

module pvr_seq
    import pvr_pkg::*;
#(
    parameter logic [`PVR_TMR_W-1:0] SRC_TRANS_CYC = `PVR_TMR_W'(`PVR_US2CYC(`PVR_SRC_TRANS_US)),
    parameter logic [`PVR_TMR_W-1:0] SRC_READY_CYC = `PVR_TMR_W'(`PVR_US2CYC(`PVR_SRC_READY_US)),
    parameter logic [`PVR_TMR_W-1:0] CRC_WAIT_CYC  = `PVR_TMR_W'(`PVR_US2CYC(`PVR_CRC_WAIT_US))
)(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rstn,
    // Policy manager
    input  wire logic                  request_ok,
    input  wire logic                  supply_ready,
    output logic                       supply_cmd,
    output logic                       busy,
    output logic                       complete,
    output logic [`PVR_ERR_W-1:0]      err,
    // Protocol layer
    output logic                       tx_accept,
    output logic                       tx_ps_rdy,
    input  wire logic                  rx_goodcrc
);

    ////////////////////////////////////////////////////////////////////////
    // Timer

    pvr_tmr_if tif ();

    pvr_timer u_timer (
        .clock (clock),
        .rstn  (rstn),
        .tif   (tif.tmr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    pvr_seq_t q;
    pvr_seq_t d;
    logic     tmr_start;
    logic [`PVR_TMR_W-1:0] tmr_limit;

    always_comb begin
        d           = q;
        d.tx_accept = 1'b0;
        d.tx_ps_rdy = 1'b0;
        d.complete  = 1'b0;
        tmr_start   = 1'b0;
        tmr_limit   = CRC_WAIT_CYC;
        case (q.state)
            PVR_IDLE: begin
                if (request_ok) begin
                    d.tx_accept = 1'b1;
                    d.busy      = 1'b1;
                    d.err       = `PVR_ERR_NONE;
                    d.state     = PVR_SEND_ACCEPT;
                end
            end
            PVR_SEND_ACCEPT: begin
                tmr_start = 1'b1;
                d.state   = PVR_WAIT_CRC_ACC;
            end
            PVR_WAIT_CRC_ACC: begin
                if (rx_goodcrc) begin
                    tmr_start = 1'b1;
                    tmr_limit = SRC_TRANS_CYC;
                    d.state   = PVR_WAIT_TRANS;
                end else if (tif.expired) begin
                    d.err   = `PVR_ERR_CRC;
                    d.busy  = 1'b0;
                    d.state = PVR_IDLE;
                end
            end
            PVR_WAIT_TRANS: begin
                // Sink standby fits inside this wait
                if (tif.expired) begin
                    d.supply_cmd = 1'b1;
                    tmr_start    = 1'b1;
                    tmr_limit    = SRC_READY_CYC;
                    d.state      = PVR_WAIT_SUPPLY;
                end
            end
            PVR_WAIT_SUPPLY: begin
                if (supply_ready) begin
                    d.tx_ps_rdy = 1'b1;
                    d.state     = PVR_SEND_RDY;
                end else if (tif.expired) begin
                    d.err        = `PVR_ERR_READY;
                    d.supply_cmd = 1'b0;
                    d.busy       = 1'b0;
                    d.state      = PVR_IDLE;
                end
            end
            PVR_SEND_RDY: begin
                tmr_start = 1'b1;
                d.state   = PVR_WAIT_CRC_RDY;
            end
            PVR_WAIT_CRC_RDY: begin
                // done only on GoodCRC for PS_RDY
                if (rx_goodcrc) begin
                    d.complete = 1'b1;
                    d.busy     = 1'b0;
                    d.state    = PVR_IDLE;
                end else if (tif.expired) begin
                    d.err   = `PVR_ERR_CRC;
                    d.busy  = 1'b0;
                    d.state = PVR_IDLE;
                end
            end
            default: begin
                d = '0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tif.start  = tmr_start;
    assign tif.limit  = tmr_limit;

    // The supply stays commanded after success; the policy manager owns it
    assign supply_cmd = q.supply_cmd;
    assign busy       = q.busy;
    assign complete   = q.complete;
    assign err        = q.err;
    assign tx_accept  = q.tx_accept;
    assign tx_ps_rdy  = q.tx_ps_rdy;

endmodule // pvr_seq

// >>> rtl/pvr_params.svh
/*
 * Constants for the source-side contract raise sequencer: timing figures,
 * timer and error code widths and error codes.
 * Assumes a 125 MHz local clock; included by bare name.
 */
`ifndef PVR_PARAMS_SVH
`define PVR_PARAMS_SVH

// Local clock period in picoseconds
`define PVR_CLK_PS          8000
// Default source transition wait in microseconds
`define PVR_SRC_TRANS_US    25
// Default supply ready limit in microseconds
`define PVR_SRC_READY_US    285000
// Default wait for each GoodCRC, in microseconds
`define PVR_CRC_WAIT_US     1000
// Timer width, enough for the longest default count
`define PVR_TMR_W           32
// Cycles from microseconds, rounded down for a longest time
`define PVR_US2CYC(us)      (((us) * 1000000) / `PVR_CLK_PS)
// Error code width and codes
`define PVR_ERR_W           2
`define PVR_ERR_NONE        2'h0
`define PVR_ERR_CRC         2'h1
`define PVR_ERR_READY       2'h2

`endif

// >>> rtl/pvr_pkg.sv
/*
 * Types for the source-side contract raise sequencer.
 * Assumes pvr_params.svh sits on the include path.
 */
`include "pvr_params.svh"

package pvr_pkg;

    typedef enum logic [2:0] {
        PVR_IDLE,
        PVR_SEND_ACCEPT,
        PVR_WAIT_CRC_ACC,
        PVR_WAIT_TRANS,
        PVR_WAIT_SUPPLY,
        PVR_SEND_RDY,
        PVR_WAIT_CRC_RDY
    } pvr_state_t;

    typedef struct packed {
        logic [`PVR_TMR_W-1:0] count;
        logic                  run;
        logic                  done;
    } pvr_tmr_t;

    typedef struct packed {
        pvr_state_t            state;
        logic                  tx_accept;
        logic                  tx_ps_rdy;
        logic                  supply_cmd;
        logic                  busy;
        logic                  complete;
        logic [`PVR_ERR_W-1:0] err;
    } pvr_seq_t;

endpackage

// >>> rtl/pvr_tmr_if.sv
/*
 * Timer control carrier between the sequencer and its down-counter.
 * Assumes one clock domain; the sequencer drives start and limit.
 */
`timescale 1ns/1ps
`include "pvr_params.svh"

interface pvr_tmr_if;
    logic                  start;
    logic [`PVR_TMR_W-1:0] limit;
    logic                  expired;

    modport ctl (output start, output limit, input expired);
    modport tmr (input start, input limit, output expired);
endinterface

// >>> rtl/pvr_timer.sv
/*
 * Interval timer: loads a terminal count on start and raises expired
 * once that many cycles have passed. A new start restarts it.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`include "pvr_params.svh"

module pvr_timer
    import pvr_pkg::*;
(
    // Clock and reset
    input  wire logic   clock,
    input  wire logic   rstn,
    // Control
    pvr_tmr_if.tmr      tif
);

    pvr_tmr_t q;
    pvr_tmr_t d;

    always_comb begin
        d = q;
        if (tif.start) begin
            d.count = tif.limit;
            d.run   = 1'b1;
            d.done  = 1'b0;
        end else if (q.run) begin
            if (q.count <= `PVR_TMR_W'(1)) begin
                d.run   = 1'b0;
                d.done  = 1'b1;
                d.count = '0;
            end else begin
                d.count = q.count - `PVR_TMR_W'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tif.expired = q.done;

endmodule // pvr_timer

// >>> testbench/pvr_seq_assertions.sv
/* Checker for the raise sequencer ports.
   Assumes the one clock and rstn of pvr_seq. */
`timescale 1ns/1ps
`include "pvr_params.svh"
module pvr_seq_assertions
    import pvr_pkg::*;
#(
    parameter logic [`PVR_TMR_W-1:0] SRC_TRANS_CYC = 8
)(
    // Clock and reset
    input wire logic                  clock,
    input wire logic                  rstn,
    // Policy manager and protocol layer
    input wire logic                  request_ok,
    input wire logic                  supply_ready,
    input wire logic                  supply_cmd,
    input wire logic                  busy,
    input wire logic                  complete,
    input wire logic [`PVR_ERR_W-1:0] err,
    input wire logic                  tx_accept,
    input wire logic                  tx_ps_rdy,
    input wire logic                  rx_goodcrc
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    accept_after_req_a: assert property (!busy && request_ok |=> tx_accept && busy)
        else $error("accept missing");
    accept_pulse_a: assert property (tx_accept |=> !tx_accept)
        else $error("accept too long");
    err_clear_a: assert property (tx_accept |-> err == `PVR_ERR_NONE)
        else $error("err not cleared");
    trans_wait_a: assert property ($rose(supply_cmd) |-> $past(rx_goodcrc, SRC_TRANS_CYC + 2))
        else $error("supply order mistimed");
    cmd_while_busy_a: assert property ($rose(supply_cmd) |-> busy && !tx_accept)
        else $error("supply order outside run");
    ps_rdy_cause_a: assert property (tx_ps_rdy |-> $past(supply_ready) && supply_cmd)
        else $error("PS_RDY without ready");
    ps_rdy_pulse_a: assert property (tx_ps_rdy |=> !tx_ps_rdy && !complete)
        else $error("PS_RDY pulse wrong");
    done_on_crc_a: assert property (complete |-> $past(rx_goodcrc) && !busy && supply_cmd)
        else $error("complete without GoodCRC");
    busy_end_a: assert property ($fell(busy) |-> complete || err != `PVR_ERR_NONE)
        else $error("busy ended silently");
    cover property (complete);
    cover property (err == `PVR_ERR_CRC);
    cover property (err == `PVR_ERR_READY);
endmodule // pvr_seq_assertions
bind pvr_seq pvr_seq_assertions #(.SRC_TRANS_CYC(SRC_TRANS_CYC)) i_pvr_seq_assertions (
    .clock(clock), .rstn(rstn), .request_ok(request_ok), .supply_ready(supply_ready),
    .supply_cmd(supply_cmd), .busy(busy), .complete(complete), .err(err),
    .tx_accept(tx_accept), .tx_ps_rdy(tx_ps_rdy), .rx_goodcrc(rx_goodcrc));

// >>> testbench/pvr_sink_model.sv
/* Sink side: answers each Accept or PS_RDY with a GoodCRC pulse unless drop is high.
   Assumes send pulses are registered outputs of the sequencer. */
`timescale 1ns/1ps
module pvr_sink_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Source messages and controls
    input wire logic tx_accept,
    input wire logic tx_ps_rdy,
    input int        dly,
    input wire logic drop,
    // Acknowledge
    output logic     rx_goodcrc
);
    logic standby = 0;
    initial rx_goodcrc = 0;
    always begin
        @(negedge clock);
        if (rstn && (tx_accept || tx_ps_rdy) && !drop) begin
            // standby long before the source wait ends
            standby = tx_accept;
            // acknowledge first, new draw left open
            repeat (dly) @(posedge clock);
            #1 rx_goodcrc = 1;
            @(posedge clock);
            #1 rx_goodcrc = 0;
        end
    end
endmodule // pvr_sink_model

// >>> testbench/test_pvr_seq.sv
/* Bench for pvr_seq with the sink model; cycle offsets are reckoned here.
   Assumes short terminal counts on the sequencer. */
`timescale 1ns/1ps
`include "pvr_params.svh"
module test_pvr_seq;
    import pvr_pkg::*;
    localparam int TR = 8;
    logic clock = 0, rstn = 0, request_ok = 0, supply_ready = 0, drop = 0;
    logic supply_cmd, busy, complete, tx_accept, tx_ps_rdy, rx_goodcrc;
    logic [`PVR_ERR_W-1:0] err;
    logic [31:0] rnd = 32'h1FA36422;
    int cyc = 0, dly = 2, t, tg, n_mismatch = 0, total_checks = 0;
    always #4 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    pvr_seq #(.SRC_TRANS_CYC(TR), .SRC_READY_CYC(20), .CRC_WAIT_CYC(10)) i_pvr_seq (
        .clock(clock), .rstn(rstn), .request_ok(request_ok), .supply_ready(supply_ready),
        .supply_cmd(supply_cmd), .busy(busy), .complete(complete), .err(err),
        .tx_accept(tx_accept), .tx_ps_rdy(tx_ps_rdy), .rx_goodcrc(rx_goodcrc));
    pvr_sink_model i_pvr_sink_model (.clock(clock), .rstn(rstn), .tx_accept(tx_accept),
        .tx_ps_rdy(tx_ps_rdy), .dly(dly), .drop(drop), .rx_goodcrc(rx_goodcrc));
    ////////////////////////////////////////
    function logic sig(input int k);
        case (k)
            0: return tx_accept;
            1: return rx_goodcrc;
            2: return supply_cmd;
            3: return tx_ps_rdy;
            4: return complete;
            default: return err != `PVR_ERR_NONE;
        endcase
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait, sampled at the falling edge where outputs are settled
    task wt(input int k, output int tt);
        for (int i = 0; i < 100 && sig(k) !== 1'b1; i++) @(negedge clock);
        chk(sig(k), 1);
        tt = cyc;
    endtask
    task drv(input logic r, input logic s);
        @(posedge clock);
        #1 request_ok = r;
        supply_ready = s;
    endtask
    // Mode 0 success, 1 lost GoodCRC for Accept, 2 supply never ready
    task run(input int mode);
        int tr;
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        dly = 2 + rnd[2:0];
        drop = (mode == 1);
        drv(1, 0);
        tr = cyc;
        @(negedge clock);
        wt(0, t);
        chk(t - tr, 1);
        drv(0, 0);
        if (mode == 1) begin
            wt(5, t);
            chk(err, `PVR_ERR_CRC);
        end else begin
            wt(1, tg);
            @(negedge clock);
            wt(2, t);
            if (mode == 0) chk(t - tg, TR + 2);
            if (mode == 2) wt(5, t);
            if (mode == 2) chk({supply_cmd, err}, {1'b0, `PVR_ERR_READY});
            if (mode == 0) begin
                repeat (rnd[7:4]) @(posedge clock);
                drv(0, 1);
                tr = cyc;
                @(negedge clock);
                wt(3, t);
                chk(t - tr, 1);
                wt(1, tg);
                @(negedge clock);
                wt(4, t);
                chk({t - tg, busy, err}, {32'h1, 1'b0, `PVR_ERR_NONE});
                drv(0, 0);
            end
        end
        $display("test mode %0d done, mismatches %0d", mode, n_mismatch);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        #1 rstn = 1;
        for (int i = 0; i < 7; i++) run(i == 0 ? 1 : (i % 2 ? 2 : 0));
        drv(0, 0);
        rstn = 0;
        drv(0, 0);
        rstn = 1;
        chk(supply_cmd, 0);
        run(0);
        give_verdict;
    end
    initial begin
        #40000;
        n_mismatch++;
        give_verdict;
    end
endmodule // test_pvr_seq
